// File: verilog/hcs_pkg.sv
// constants, codes and the state type shared by the run-control block
package hcs_pkg;

  // ***********************************************
  // register byte addresses
  // ***********************************************
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0000;
  localparam logic [31:0] ADDR_VECTOR = 32'h0000_0004;
  localparam logic [31:0] ADDR_CONTROL = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int unsigned CFG_DBG_LSB = 0;    // debug-enable setting, 2 bits
  localparam int unsigned CFG_FT_BIT = 2;     // fault_tolerance_setting
  localparam int unsigned CFG_AIRQ_BIT = 3;   // async_irq_setting
  localparam int unsigned CFG_AWAKE_LSB = 4;  // async_wake_setting, 2 bits
  localparam int unsigned CTL_WAKE_BIT = 0;   // debugger asks for wake-up
  localparam int unsigned CTL_CONT_BIT = 1;   // debugger asks to continue from pause
  localparam int unsigned CTL_HALT_BIT = 2;   // debugger halts the pipeline
  localparam int unsigned CTL_RESUME_BIT = 3; // debugger resumes execution
  localparam int unsigned STA_STATE_LSB = 0;  // 3 bits
  localparam int unsigned STA_MODE_LSB = 4;   // 2 bits
  localparam int unsigned STA_KIND_LSB = 6;   // 2 bits
  localparam int unsigned STA_HALT_BIT = 8;
  localparam int unsigned STA_PACK_BIT = 9;
  localparam int unsigned STA_FAULT_BIT = 10;
  localparam int unsigned STA_NSEC_LSB = 12;  // 4 bits
  localparam int unsigned STA_DWAKE_BIT = 16;
  localparam int unsigned STA_DCONT_BIT = 17;

  // ***********************************************
  // reset values and codes
  // ***********************************************
  localparam logic [1:0] DBG_EN_RST = 2'h0;
  localparam logic [31:0] VECTOR_RST = 32'h0000_0000;
  localparam logic [1:0] DBG_OFF = 2'h0;
  localparam logic [1:0] DBG_EXTENDED = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_HALT = 2'h2;
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_SLEEP = 2'h1;
  localparam logic [1:0] KIND_HIBERNATE = 2'h2;
  localparam logic [1:0] KIND_SUSPEND = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_RUN = 3'b001,
    ST_DRAIN = 3'b010,
    ST_SLEEP = 3'b011,
    ST_DHALT = 3'b100,
    ST_PDRAIN = 3'b101,
    ST_PAUSED = 3'b110,
    ST_FAULT = 3'b111
  } hcs_state_t;

endpackage : hcs_pkg

// File: verilog/hcs_sync_if.sv
// bundle between the run-control top and its input synchroniser
`timescale 1ns/1ns
interface hcs_sync_if #(parameter int W = 1) ();
  logic [W-1:0] raw;
  logic [W-1:0] async_en;
  logic [W-1:0] q;
  modport sink (input raw, input async_en, output q);
  modport src (output raw, output async_en, input q);
endinterface : hcs_sync_if

// File: verilog/hcs_sync.sv
// two-flop synchroniser with a per-bit bypass for inputs already on the clock
`timescale 1ns/1ns
module hcs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  hcs_sync_if.sink port
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hcs_sync_state_t;

  hcs_sync_state_t r;
  hcs_sync_state_t next_r;

  // ***********************************************
  // flop chain
  // ***********************************************
  // meta feeds stable and nothing else
  always_comb begin
    next_r = r;
    next_r.meta = port.raw;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // bypassed bits are treated as synchronous and skip the two-cycle delay
  assign port.q = (r.stable & port.async_en) | (port.raw & ~port.async_en);

endmodule : hcs_sync

// File: verilog/hcs_top.sv
// run control of the core: reset modes, sleep, pause, debug halt, register slave
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module hcs_top (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CORE_RESET,
  input wire logic [1:0] RESET_MODE,
  input wire logic [1:0] WAKEUP,
  input wire logic IRQ_IN,
  input wire logic DEBUG_UPDATE,
  input wire logic DEBUG_STOP,
  input wire logic PAUSE,
  input wire logic [3:0] NONSECURE,
  input wire logic SLEEP_VALID,
  input wire logic [1:0] SLEEP_KIND,
  input wire logic BUS_IDLE,
  input wire logic PERF_OVERFLOW,
  input wire logic MISSED_EXCEPTION,
  output logic CORE_RUN,
  output logic START_AT_VECTOR,
  output logic [31:0] RESET_VECTOR,
  output logic SLEEP,
  output logic HIBERNATE,
  output logic SUSPEND,
  output logic CORE_STOPPED_FLAG,
  output logic PAUSE_ACK,
  output logic DEBUG_WAKE_REQ,
  output logic DEBUG_CONTINUE_REQ,
  output logic DEBUG_IRQ,
  output logic FAULT_HALT,
  output logic [3:0] NONSECURE_OUT,
  output logic IRQ_CORE
);

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    hcs_pkg::hcs_state_t state;
    logic [1:0] mode;
    logic [1:0] kind;
    logic from_reset;
    logic start_pulse;
    logic stop_prev;
    logic upd_prev;
    logic dwake_pend;
    logic dwake;
    logic dcont;
    logic dbg_irq;
    logic [3:0] nonsec;
    logic [1:0] dbg_en;
    logic ft;
    logic airq;
    logic [1:0] awake;
    logic [31:0] vector;
    logic aw_hold;
    logic [31:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hcs_top_state_t;

  hcs_top_state_t r;
  hcs_top_state_t next_r;
  logic rst_meta;
  logic rst_n;
  logic stop_edge;
  logic upd_edge;
  logic halt_cmd;
  logic resume_cmd;
  logic wake_cmd;
  logic cont_cmd;
  logic [31:0] status;
  logic [31:0] config_word;

  // ***********************************************
  // reset release
  // ***********************************************
  // assertion is immediate, release is aligned to the clock
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ***********************************************
  // input synchronisers
  // ***********************************************
  hcs_sync_if #(.W(3)) crst_if ();
  hcs_sync_if #(.W(2)) wake_if ();
  hcs_sync_if #(.W(1)) irq_if ();
  hcs_sync_if #(.W(1)) upd_if ();

  // core reset and its mode straps always come through two flops
  assign crst_if.raw = {RESET_MODE, CORE_RESET};
  assign crst_if.async_en = 3'h7;
  assign wake_if.raw = WAKEUP;
  assign wake_if.async_en = r.awake;
  assign irq_if.raw = IRQ_IN;
  assign irq_if.async_en = r.airq;
  assign upd_if.raw = DEBUG_UPDATE;
  assign upd_if.async_en = 1'h1;

  hcs_sync #(.W(3)) u_crst_sync (.clk(CLOCK), .rst_n(rst_n), .port(crst_if.sink));
  hcs_sync #(.W(2)) u_wake_sync (.clk(CLOCK), .rst_n(rst_n), .port(wake_if.sink));
  hcs_sync #(.W(1)) u_irq_sync (.clk(CLOCK), .rst_n(rst_n), .port(irq_if.sink));
  hcs_sync #(.W(1)) u_upd_sync (.clk(CLOCK), .rst_n(rst_n), .port(upd_if.sink));

  // ***********************************************
  // read views
  // ***********************************************
  always_comb begin
    config_word = '0;
    config_word[hcs_pkg::CFG_DBG_LSB +: 2] = r.dbg_en;
    config_word[hcs_pkg::CFG_FT_BIT] = r.ft;
    config_word[hcs_pkg::CFG_AIRQ_BIT] = r.airq;
    config_word[hcs_pkg::CFG_AWAKE_LSB +: 2] = r.awake;
    status = '0;
    status[hcs_pkg::STA_STATE_LSB +: 3] = r.state;
    status[hcs_pkg::STA_MODE_LSB +: 2] = r.mode;
    status[hcs_pkg::STA_KIND_LSB +: 2] = r.kind;
    status[hcs_pkg::STA_HALT_BIT] = CORE_STOPPED_FLAG;
    status[hcs_pkg::STA_PACK_BIT] = PAUSE_ACK;
    status[hcs_pkg::STA_FAULT_BIT] = FAULT_HALT;
    status[hcs_pkg::STA_NSEC_LSB +: 4] = r.nonsec;
    status[hcs_pkg::STA_DWAKE_BIT] = r.dwake;
    status[hcs_pkg::STA_DCONT_BIT] = r.dcont;
  end

  // ***********************************************
  // next-state logic
  // ***********************************************
  always_comb begin
    next_r = r;
    next_r.start_pulse = 1'b0;
    next_r.stop_prev = DEBUG_STOP;
    next_r.upd_prev = upd_if.q;
    next_r.nonsec = NONSECURE;
    halt_cmd = 1'b0;
    resume_cmd = 1'b0;
    wake_cmd = 1'b0;
    cont_cmd = 1'b0;
    // stop only counts on its rising edge and with debug present
    stop_edge = DEBUG_STOP & ~r.stop_prev & (r.dbg_en != hcs_pkg::DBG_OFF);
    upd_edge = upd_if.q & ~r.upd_prev;
    // overflow only reaches the debug interrupt in extended debug
    next_r.dbg_irq = PERF_OVERFLOW & (r.dbg_en == hcs_pkg::DBG_EXTENDED);

    // write channel: address and data are held until both have arrived
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_r.aw_hold = 1'b1;
      next_r.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_r.w_hold = 1'b1;
      next_r.wdata = S_AXI_WDATA;
      next_r.wstrb = S_AXI_WSTRB;
    end
    if (r.bvalid && S_AXI_BREADY) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = hcs_pkg::RESP_OKAY;
      case (r.awaddr)
        hcs_pkg::ADDR_CONFIG: begin
          if (r.wstrb[0]) begin
            next_r.dbg_en = r.wdata[hcs_pkg::CFG_DBG_LSB +: 2];
            next_r.ft = r.wdata[hcs_pkg::CFG_FT_BIT];
            next_r.airq = r.wdata[hcs_pkg::CFG_AIRQ_BIT];
            next_r.awake = r.wdata[hcs_pkg::CFG_AWAKE_LSB +: 2];
          end
        end
        hcs_pkg::ADDR_VECTOR: begin
          for (int i = 0; i < 4; i++) begin
            if (r.wstrb[i]) begin
              next_r.vector[8*i +: 8] = r.wdata[8*i +: 8];
            end
          end
        end
        hcs_pkg::ADDR_CONTROL: begin
          // command bits are one-shot; they are never stored
          if (r.wstrb[0]) begin
            wake_cmd = r.wdata[hcs_pkg::CTL_WAKE_BIT];
            cont_cmd = r.wdata[hcs_pkg::CTL_CONT_BIT];
            halt_cmd = r.wdata[hcs_pkg::CTL_HALT_BIT];
            resume_cmd = r.wdata[hcs_pkg::CTL_RESUME_BIT];
          end
        end
        hcs_pkg::ADDR_STATUS: begin
          next_r.bresp = hcs_pkg::RESP_OKAY; // read-only, write dropped
        end
        default: begin
          next_r.bresp = hcs_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read channel: one read in flight, answered the cycle after address
    if (r.rvalid && S_AXI_RREADY) begin
      next_r.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = hcs_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        hcs_pkg::ADDR_CONFIG: next_r.rdata = config_word;
        hcs_pkg::ADDR_VECTOR: next_r.rdata = r.vector;
        hcs_pkg::ADDR_CONTROL: next_r.rdata = '0;
        hcs_pkg::ADDR_STATUS: next_r.rdata = status;
        default: begin
          next_r.rdata = '0;
          next_r.rresp = hcs_pkg::RESP_SLVERR;
        end
      endcase
    end

    // run control; core reset overrides every state
    if (crst_if.q[0]) begin
      next_r.state = hcs_pkg::ST_HOLD;
      next_r.mode = crst_if.q[2:1];
      next_r.kind = hcs_pkg::KIND_NONE;
      next_r.from_reset = 1'b1;
      next_r.dwake_pend = 1'b0;
      next_r.dwake = 1'b0;
      next_r.dcont = 1'b0;
    end else begin
      case (r.state)
        hcs_pkg::ST_HOLD: begin
          // mode applied at release; no bus access before leaving here
          if (r.mode == hcs_pkg::MODE_SLEEP) begin
            next_r.state = hcs_pkg::ST_SLEEP;
            next_r.kind = hcs_pkg::KIND_SLEEP;
          end else if (r.mode == hcs_pkg::MODE_HALT &&
                       r.dbg_en != hcs_pkg::DBG_OFF) begin
            next_r.state = hcs_pkg::ST_DHALT;
          end else begin
            // normal start, also mode 10 without debug and reserved 11
            next_r.state = hcs_pkg::ST_RUN;
            next_r.start_pulse = 1'b1;
            next_r.from_reset = 1'b0;
          end
        end
        hcs_pkg::ST_RUN: begin
          // fault beats debug, debug beats sleep, sleep beats pause
          if (MISSED_EXCEPTION && r.ft) begin
            next_r.state = hcs_pkg::ST_FAULT;
          end else if (halt_cmd || stop_edge) begin
            next_r.state = hcs_pkg::ST_DHALT;
          end else if (SLEEP_VALID && SLEEP_KIND != hcs_pkg::KIND_NONE) begin
            next_r.state = hcs_pkg::ST_DRAIN;
            next_r.kind = SLEEP_KIND;
          end else if (PAUSE) begin
            next_r.state = hcs_pkg::ST_PDRAIN;
          end
        end
        hcs_pkg::ST_DRAIN: begin
          // sleep outputs wait for the last external access to finish
          if (halt_cmd || stop_edge) begin
            next_r.state = hcs_pkg::ST_DHALT;
            next_r.kind = hcs_pkg::KIND_NONE;
          end else if (BUS_IDLE) begin
            next_r.state = hcs_pkg::ST_SLEEP;
          end
        end
        hcs_pkg::ST_SLEEP: begin
          // debugger wake request is only raised on an update edge; a wake clears it at once
          if (wake_cmd) begin
            next_r.dwake_pend = 1'b1;
          end
          if (upd_edge) begin
            next_r.dwake = r.dwake_pend | wake_cmd;
          end
          if (|wake_if.q) begin
            next_r.state = hcs_pkg::ST_RUN;
            next_r.kind = hcs_pkg::KIND_NONE;
            next_r.start_pulse = r.from_reset;
            next_r.from_reset = 1'b0;
            next_r.dwake_pend = 1'b0;
            next_r.dwake = 1'b0;
          end
        end
        hcs_pkg::ST_DHALT: begin
          if (resume_cmd) begin
            next_r.state = hcs_pkg::ST_RUN;
            next_r.start_pulse = r.from_reset;
            next_r.from_reset = 1'b0;
          end
        end
        hcs_pkg::ST_PDRAIN: begin
          if (halt_cmd || stop_edge) begin
            next_r.state = hcs_pkg::ST_DHALT;
          end else if (!PAUSE) begin
            next_r.state = hcs_pkg::ST_RUN;
          end else if (BUS_IDLE) begin
            next_r.state = hcs_pkg::ST_PAUSED;
          end
        end
        hcs_pkg::ST_PAUSED: begin
          if (!PAUSE) begin
            next_r.state = hcs_pkg::ST_RUN;
            next_r.dcont = 1'b0;
          end else if (cont_cmd) begin
            next_r.dcont = 1'b1;
          end
        end
        hcs_pkg::ST_FAULT: begin
          next_r.state = hcs_pkg::ST_FAULT; // left only by core reset
        end
        default: begin
          next_r.state = hcs_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // ***********************************************
  // state register
  // ***********************************************
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= hcs_pkg::ST_HOLD;
      r.dbg_en <= hcs_pkg::DBG_EN_RST;
      r.vector <= hcs_pkg::VECTOR_RST;
      r.from_reset <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  // bus handshakes are combinational from the hold and valid flags
  assign S_AXI_AWREADY = ~r.aw_hold;
  assign S_AXI_WREADY = ~r.w_hold;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = ~r.rvalid;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;

  // status pins decode the state flops directly, except IRQ_CORE, which comes from the interrupt synchroniser
  assign CORE_RUN = (r.state == hcs_pkg::ST_RUN);
  assign START_AT_VECTOR = r.start_pulse;
  assign RESET_VECTOR = r.vector;
  assign SLEEP = (r.state == hcs_pkg::ST_SLEEP) && (r.kind == hcs_pkg::KIND_SLEEP);
  assign HIBERNATE = (r.state == hcs_pkg::ST_SLEEP) &&
                     (r.kind == hcs_pkg::KIND_HIBERNATE);
  assign SUSPEND = (r.state == hcs_pkg::ST_SLEEP) && (r.kind == hcs_pkg::KIND_SUSPEND);
  assign CORE_STOPPED_FLAG = (r.state == hcs_pkg::ST_DHALT);
  assign PAUSE_ACK = (r.state == hcs_pkg::ST_PAUSED);
  assign DEBUG_WAKE_REQ = r.dwake;
  assign DEBUG_CONTINUE_REQ = r.dcont;
  assign DEBUG_IRQ = r.dbg_irq;
  assign FAULT_HALT = (r.state == hcs_pkg::ST_FAULT);
  assign NONSECURE_OUT = r.nonsec;
  assign IRQ_CORE = irq_if.q;

endmodule : hcs_top

// File: verification/hcs_top_properties.sv
// checker for the run-control top, bound to its ports
`timescale 1ns/1ns
module hcs_top_properties (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic BUS_IDLE,
  input wire logic PAUSE,
  input wire logic PAUSE_ACK,
  input wire logic SLEEP,
  input wire logic HIBERNATE,
  input wire logic SUSPEND,
  input wire logic [1:0] WAKEUP,
  input wire logic CORE_RESET,
  input wire logic START_AT_VECTOR,
  input wire logic CORE_RUN,
  input wire logic [3:0] NONSECURE,
  input wire logic [3:0] NONSECURE_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // a response must stand with its payload until the master takes it
  chk_bresp_stands:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  chk_rdata_stands:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  chk_ar_refused:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
  // a read answer only follows an accepted read address
  chk_read_answer:
    assert property ($rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID) && $past(S_AXI_ARREADY))
    else $error("read answered without request");
  chk_low_power_idle:
    assert property ($rose(HIBERNATE) || $rose(SUSPEND) |-> $past(BUS_IDLE))
    else $error("low power entered with bus busy");
  chk_ack_after_idle:
    assert property ($rose(PAUSE_ACK) |-> $past(BUS_IDLE) && $past(PAUSE))
    else $error("pause ack without idle bus");
  chk_ack_drop:
    assert property (PAUSE_ACK && !PAUSE |=> !PAUSE_ACK) else $error("pause ack held");
  // both wake paths are at most two flops deep, so three quiet samples suffice
  chk_sleep_holds:
    assert property ((WAKEUP == 2'h0) [*3] ##0 SLEEP && !CORE_RESET |=> SLEEP)
    else $error("sleep left without wake");
  chk_start_run:
    assert property (START_AT_VECTOR |-> CORE_RUN ##1 !START_AT_VECTOR)
    else $error("start pulse wrong");
  chk_nonsec_follow:
    assert property (NONSECURE_OUT == $past(NONSECURE)) else $error("nonsecure mismatch");
  chk_one_state:
    assert property ($onehot0({SLEEP, HIBERNATE, SUSPEND, PAUSE_ACK, CORE_RUN}))
    else $error("two run states at once");
endmodule : hcs_top_properties

bind hcs_top hcs_top_properties hcs_top_properties_i (.*);

// File: verification/hcs_partner.sv
// far-side model: clock and pause control answering the debug requests
`timescale 1ns/1ns
module hcs_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pause_cmd,
  input wire logic wake_req,
  input wire logic cont_req,
  output logic pause,
  output logic wake
);
  logic cut;
  // a continue request releases pause until the system drops its own request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= 1'b0;
      cut <= 1'b0;
    end else begin
      wake <= wake_req;
      if (cont_req) cut <= 1'b1;
      else if (!pause_cmd) cut <= 1'b0;
    end
  end
  assign pause = pause_cmd & ~cut;
endmodule : hcs_partner

// File: verification/hcs_top_bench.sv
// self-checking bench for the run-control top
`timescale 1ns/1ns
module hcs_top_bench;
  logic CLOCK = 1'b0, RESET_N = 1'b0, CORE_RESET = 1'b0, IRQ_IN = 1'b0, DEBUG_STOP = 1'b0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0, SLEEP_VALID = 1'b0, BUS_IDLE = 1'b1, PERF_OVERFLOW = 1'b0;
  logic MISSED_EXCEPTION = 1'b0, pause_cmd = 1'b0, wake0 = 1'b0, wake1, PAUSE, DEBUG_UPDATE;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, CORE_RUN;
  logic START_AT_VECTOR, SLEEP, HIBERNATE, SUSPEND, CORE_STOPPED_FLAG, PAUSE_ACK, DEBUG_IRQ;
  logic DEBUG_WAKE_REQ, DEBUG_CONTINUE_REQ, FAULT_HALT, IRQ_CORE;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, WAKEUP, RESET_MODE = 2'h0, SLEEP_KIND = 2'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF, NONSECURE = 4'h0, NONSECURE_OUT;
  logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
  logic [31:0] S_AXI_RDATA, RESET_VECTOR;
  logic [2:0] ucnt = 3'h0;
  int n_mismatch = 0, comparisons = 0, n_start = 0, n_irq = 0, s, i;
  hcs_top hcs_top_i (.*);
  hcs_partner hcs_partner_i (.clk(CLOCK), .rst_n(RESET_N), .pause_cmd(pause_cmd),
    .wake_req(DEBUG_WAKE_REQ), .cont_req(DEBUG_CONTINUE_REQ), .pause(PAUSE), .wake(wake1));
  assign WAKEUP = {wake1, wake0};
  assign DEBUG_UPDATE = ucnt[2];
  always #2 CLOCK = ~CLOCK;
  // slow debug update strobe plus pulse counters
  always @(posedge CLOCK) begin
    ucnt <= ucnt + 3'h1;
    n_start += START_AT_VECTOR;
    n_irq += DEBUG_IRQ;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : cyc
  task expire(input int n);
    if (n >= 300) begin
      n_mismatch++;
      $display("Error at %0t: wait timed out", $time);
      results();
    end
  endtask : expire
  function logic pick(input int k);
    case (k)
      0: return SLEEP;
      1: return HIBERNATE;
      2: return SUSPEND;
      3: return PAUSE_ACK;
      4: return CORE_STOPPED_FLAG;
      5: return CORE_RUN;
      default: return FAULT_HALT;
    endcase
  endfunction : pick
  task wait_on(input int k, input logic v);
    int n;
    for (n = 0; n < 300 && pick(k) !== v; n++) @(posedge CLOCK);
    expire(n);
  endtask : wait_on
  // write: address and data offered together, each released once taken
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge CLOCK);
      if (S_AXI_BVALID === 1'b1) break;
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end
    expire(n);
    chk(32'(S_AXI_BRESP), 32'(e));
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge CLOCK);
      if (S_AXI_RVALID === 1'b1) break;
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end
    expire(n);
    chk(S_AXI_RDATA, d);
    chk(32'(S_AXI_RRESP), 32'(e));
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  // core reset held sixteen cycles, mode kept steady until the next reset
  task creset(input logic [1:0] m);
    @(posedge CLOCK);
    CORE_RESET <= 1'b1;
    RESET_MODE <= m;
    cyc(16);
    CORE_RESET <= 1'b0;
  endtask : creset
  task t_regs;
    rd(hcs_pkg::ADDR_CONFIG, 32'h0, hcs_pkg::RESP_OKAY);
    rd(hcs_pkg::ADDR_VECTOR, 32'h0, hcs_pkg::RESP_OKAY);
    rd(hcs_pkg::ADDR_STATUS, 32'h1, hcs_pkg::RESP_OKAY);
    wr(hcs_pkg::ADDR_VECTOR, 32'h100, hcs_pkg::RESP_OKAY);
    rd(hcs_pkg::ADDR_VECTOR, 32'h100, hcs_pkg::RESP_OKAY);
    rd(hcs_pkg::ADDR_CONTROL, 32'h0, hcs_pkg::RESP_OKAY);
    rd(32'h10, 32'h0, hcs_pkg::RESP_SLVERR);
    wr(32'h10, 32'h5, hcs_pkg::RESP_SLVERR);
    $display("regs done");
  endtask : t_regs
  // modes 00 01 10 11 with debug off, then 10 with debug on
  task t_modes;
    for (i = 0; i < 5; i++) begin
      wr(hcs_pkg::ADDR_CONFIG, 32'(i == 4), hcs_pkg::RESP_OKAY);
      s = n_start;
      creset(i < 4 ? 2'(i) : hcs_pkg::MODE_HALT);
      if (i == 1) begin
        wait_on(0, 1'b1);
        cyc(3);
        chk(32'(n_start), 32'(s));
        wake0 <= 1'b1;
        wait_on(5, 1'b1);
        wake0 <= 1'b0;
      end else if (i == 4) begin
        wait_on(4, 1'b1);
        chk(32'(CORE_RUN), 32'h0);
        wr(hcs_pkg::ADDR_CONTROL, 32'h8, hcs_pkg::RESP_OKAY);
      end
      wait_on(5, 1'b1);
      cyc(1);
      chk(32'(n_start), 32'(s + 1));
      chk(RESET_VECTOR, 32'h100);
    end
    $display("reset modes done");
  endtask : t_modes
  task t_sleep;
    for (i = 1; i < 4; i++) begin
      wr(hcs_pkg::ADDR_CONFIG, 32'(i) << 4, hcs_pkg::RESP_OKAY);
      s = n_start;
      BUS_IDLE <= 1'b0;
      SLEEP_VALID <= 1'b1;
      SLEEP_KIND <= 2'(i);
      @(posedge CLOCK);
      SLEEP_VALID <= 1'b0;
      cyc(4);
      chk(32'(pick(i - 1)), 32'h0);
      BUS_IDLE <= 1'b1;
      wait_on(i - 1, 1'b1);
      cyc(6);
      chk(32'(pick(i - 1)), 32'h1);
      wr(hcs_pkg::ADDR_CONTROL, 32'h1, hcs_pkg::RESP_OKAY);
      wait_on(5, 1'b1);
      cyc(1);
      chk(32'(n_start), 32'(s));
    end
    $display("sleep done");
  endtask : t_sleep
  // pause left once by a debug continue request and once by the system itself
  task t_pause;
    for (i = 0; i < 2; i++) begin
      s = n_start;
      BUS_IDLE <= 1'b0;
      pause_cmd <= 1'b1;
      cyc(4);
      chk(32'(PAUSE_ACK), 32'h0);
      BUS_IDLE <= 1'b1;
      wait_on(3, 1'b1);
      chk(32'(CORE_RUN), 32'h0);
      if (i == 0) wr(hcs_pkg::ADDR_CONTROL, 32'h2, hcs_pkg::RESP_OKAY);
      else pause_cmd <= 1'b0;
      wait_on(3, 1'b0);
      pause_cmd <= 1'b0;
      // partner must see pause low and clear its cut before the next request
      cyc(2);
      wait_on(5, 1'b1);
      chk(32'(n_start), 32'(s));
    end
    $display("pause done");
  endtask : t_pause
  task t_debug;
    for (i = 0; i < 3; i++) begin
      wr(hcs_pkg::ADDR_CONFIG, 32'(i), hcs_pkg::RESP_OKAY);
      s = n_irq;
      DEBUG_STOP <= 1'b1;
      PERF_OVERFLOW <= 1'b1;
      @(posedge CLOCK);
      DEBUG_STOP <= 1'b0;
      PERF_OVERFLOW <= 1'b0;
      cyc(4);
      chk(32'(CORE_STOPPED_FLAG), 32'(i != 0));
      chk(32'(n_irq), 32'(s + (i == 2)));
      if (i != 0) wr(hcs_pkg::ADDR_CONTROL, 32'h8, hcs_pkg::RESP_OKAY);
      wait_on(5, 1'b1);
    end
    $display("debug done");
  endtask : t_debug
  task t_misc;
    wr(hcs_pkg::ADDR_CONFIG, 32'h4, hcs_pkg::RESP_OKAY);
    MISSED_EXCEPTION <= 1'b1;
    @(posedge CLOCK);
    MISSED_EXCEPTION <= 1'b0;
    wait_on(6, 1'b1);
    creset(hcs_pkg::MODE_NORMAL);
    wait_on(5, 1'b1);
    chk(32'(FAULT_HALT), 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(hcs_pkg::ADDR_CONFIG, 32'(i) << 3, hcs_pkg::RESP_OKAY);
      IRQ_IN <= 1'b1;
      @(posedge CLOCK);
      chk(32'(IRQ_CORE), 32'(i == 0));
      cyc(2);
      chk(32'(IRQ_CORE), 32'h1);
      IRQ_IN <= 1'b0;
    end
    NONSECURE <= 4'hA;
    cyc(2);
    chk(32'(NONSECURE_OUT), 32'hA);
    $display("misc done");
  endtask : t_misc
  initial begin
    cyc(3);
    RESET_N <= 1'b1;
    cyc(3);
    t_regs();
    t_modes();
    t_sleep();
    t_pause();
    t_debug();
    t_misc();
    results();
  end
endmodule : hcs_top_bench
